/* hdl/adc_config_serial_port.sv */
// Setup register and serial port of a 16-bit sensor converter.
// Assumes a host in SPI mode 1 owning sclk, cs_n and din; the converter
// core sits on ref_clk and reports results through conv_done.
// Function
// - Gain field bits 11:9, reset 2, selects full-scale span.
// - Bit 8 picks continuous (0) or single-shot power-down (1, reset).
// - Rate field bits 7:5 decodes 8 to 860 samples per second, reset 128.
// - Bit 4 picks analog inputs (0, reset) or temperature sensor (1).
// - With chip select high, weak pullup on data-out when bit 3 set.
// - Setup updates only when received bits 2:1 equal 01.
// - Bit 0 ignores writes and always reads one.
// - Mode 1: clock idles low, launch rising, sample falling.
// - Abandon the frame when serial clock stays low over 30.8 ms.
// - Bit 15 starts one conversion when powered down; reads zero.
// - Bits 14:12 select input pair, differential or against ground.
// - Chip select high resets the port; next frame sends buffered result.
// - 32-bit frame echoes an accepted setup, else the stored one, in its last two bytes.
`timescale 1ns/10ps
`default_nettype none
module adc_config_serial_port #(
    parameter int TIMEOUT_CYCLES = adc_setup_pkg::SCLK_TIMEOUT_CYCLES
) (
    input  wire logic                          ref_clk,
    input  wire logic                          reset_n,
    input  wire logic                          sclk,
    input  wire logic                          cs_n,
    input  wire logic                          din,
    output var  logic                          dout_o,
    output var  logic                          dout_oe_n,
    output var  logic                          dout_pullup_on,
    input  wire logic                          conv_done,
    input  wire logic [15:0]                   conv_data,
    input  wire logic                          conv_busy,
    output var  logic                          conv_start,
    output var  adc_setup_pkg::setup_type       setup,
    output var  adc_setup_pkg::input_route_type input_route,
    output var  logic [12:0]                   full_scale_span_mv,
    output var  logic [9:0]                    sample_rate_sps
);
    // Elaboration guard on the timeout length
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << adc_setup_pkg::TIMEOUT_CNT_W))
    begin : g_bad_timeout
        $error("TIMEOUT_CYCLES out of range for the stall counter");
    end

    localparam logic [adc_setup_pkg::TIMEOUT_CNT_W-1:0] TIMEOUT_LIMIT =
        (adc_setup_pkg::TIMEOUT_CNT_W)'(TIMEOUT_CYCLES);

    typedef struct packed {
        adc_setup_pkg::setup_type                setup;
        logic                                    toggle_seen;
        logic [adc_setup_pkg::TIMEOUT_CNT_W-1:0] idle_cnt;
        logic                                    abort;
        logic [15:0]                             result;
        logic [15:0]                             pending;
        logic                                    pending_valid;
        logic                                    ready;
        logic                                    start;
        logic                                    cs_seen;
    } core_state_type;

    core_state_type state_reg;
    core_state_type state_next;

    logic        cs_sync;
    logic        sclk_sync;
    logic        toggle_sync;
    logic [15:0] rx_word;
    logic        word_toggle;
    logic        tx_bit;
    logic        started;
    logic        frame_rst_n;
    logic        new_word;
    logic        write_ok;
    logic [15:0] setup_readback;

    // Pins and the link toggle enter the core through two flops each
    level_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in ({cs_n, sclk, word_toggle}),
        .sync_out ({cs_sync, sclk_sync, toggle_sync})
    );

    // chip select high holds the link in reset
    // a timed-out frame is held in reset until chip select rises
    assign frame_rst_n = reset_n & ~cs_n & ~state_reg.abort;

    // Result word only changes between frames and readback only after a frame's first half,
    // so the link samples them as quiet words
    // reserved bit reads one
    assign setup_readback = adc_setup_pkg::setup_word(state_reg.setup);

    serial_link u_link (
        .sclk           (sclk),
        .frame_rst_n    (frame_rst_n),
        .reset_n        (reset_n),
        .din            (din),
        .result_word    (state_reg.result),
        .setup_readback (setup_readback),
        .rx_word        (rx_word),
        .word_toggle    (word_toggle),
        .tx_bit         (tx_bit),
        .started        (started)
    );

    // Word from the link lands here once per frame, after its first half
    assign new_word = toggle_sync ^ state_reg.toggle_seen;
    // constant data-in gives 00 or 11 and never updates
    assign write_ok = new_word
        && (rx_word[adc_setup_pkg::CODE_MSB:adc_setup_pkg::CODE_LSB]
            == adc_setup_pkg::WRITE_VALID_CODE);

    always_comb
    begin
        state_next             = state_reg;
        state_next.toggle_seen = toggle_sync;
        state_next.cs_seen     = cs_sync;
        state_next.start       = 1'h0;

        if (write_ok)
        begin
            state_next.setup.input_pair_sel =
                rx_word[adc_setup_pkg::MUX_MSB:adc_setup_pkg::MUX_LSB];
            state_next.setup.gain_range_sel =
                rx_word[adc_setup_pkg::GAIN_MSB:adc_setup_pkg::GAIN_LSB];
            state_next.setup.single_shot = rx_word[adc_setup_pkg::MODE_BIT];
            state_next.setup.sample_rate_sel =
                rx_word[adc_setup_pkg::RATE_MSB:adc_setup_pkg::RATE_LSB];
            state_next.setup.temp_source_sel = rx_word[adc_setup_pkg::TEMP_BIT];
            state_next.setup.pullup_en = rx_word[adc_setup_pkg::PULLUP_BIT];
            // single-shot start when idle and powered down
            state_next.start = rx_word[adc_setup_pkg::SS_BIT] && !conv_busy
                && (state_reg.setup.single_shot == adc_setup_pkg::MODE_SINGLE);
        end

        // stall counter runs while the clock sits low in a frame
        if (cs_sync || sclk_sync)
            state_next.idle_cnt = '0;
        else if (state_reg.idle_cnt != TIMEOUT_LIMIT)
            state_next.idle_cnt = state_reg.idle_cnt + 1'h1;
        // more than the limit abandons the frame
        if (cs_sync)
            state_next.abort = 1'h0;
        else if (state_reg.idle_cnt == TIMEOUT_LIMIT && !sclk_sync)
            state_next.abort = 1'h1;

        // results wait while a frame runs, so a frame never tears
        if (conv_done)
        begin
            if (cs_sync)
            begin
                state_next.result = conv_data;
                state_next.ready  = 1'h1;
            end
            else
            begin
                state_next.pending       = conv_data;
                state_next.pending_valid = 1'h1;
            end
        end
        else if (cs_sync && state_reg.pending_valid)
        begin
            state_next.result        = state_reg.pending;
            state_next.pending_valid = 1'h0;
            state_next.ready         = 1'h1;
        end

        // Falling chip select hands the ready result to the frame
        if (state_reg.cs_seen && !cs_sync && !conv_done)
            state_next.ready = 1'h0;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg         <= '0;
            state_reg.setup   <= adc_setup_pkg::SETUP_RST;
            state_reg.cs_seen <= 1'h1;
        end
        else
            state_reg <= state_next;
    end

    // pullup only while chip select is high and enabled
    assign dout_pullup_on = cs_n & state_reg.setup.pullup_en;
    // Driven whenever the frame is open; low means driving
    assign dout_oe_n = cs_n;
    // Before the first rising edge the pin shows data ready, low for new
    assign dout_o = started ? tx_bit : ~state_reg.ready;

    assign conv_start         = state_reg.start;
    assign setup              = state_reg.setup;
    assign input_route        = adc_setup_pkg::input_route(state_reg.setup.input_pair_sel);
    assign full_scale_span_mv = adc_setup_pkg::full_scale_span(state_reg.setup.gain_range_sel);
    assign sample_rate_sps    = adc_setup_pkg::rate_sps(state_reg.setup.sample_rate_sel);
endmodule : adc_config_serial_port
`default_nettype wire

/* hdl/adc_setup_pkg.sv */
// Shared constants, field layout and carrier types for the converter setup port.
// Assumes a 100 MHz reference clock; the serial clock comes from the host.
package adc_setup_pkg;

    // Word layout of the setup register
    localparam int WORD_W     = 16;
    localparam int SS_BIT     = 15;
    localparam int MUX_MSB    = 14;
    localparam int MUX_LSB    = 12;
    localparam int GAIN_MSB   = 11;
    localparam int GAIN_LSB   = 9;
    localparam int MODE_BIT   = 8;
    localparam int RATE_MSB   = 7;
    localparam int RATE_LSB   = 5;
    localparam int TEMP_BIT   = 4;
    localparam int PULLUP_BIT = 3;
    localparam int CODE_MSB   = 2;
    localparam int CODE_LSB   = 1;

    // Fixed read values and the only accepted write code
    localparam logic [1:0] WRITE_VALID_CODE = 2'h1;
    localparam logic       SS_READ          = 1'h0;
    localparam logic       RSVD_READ        = 1'h1;

    // Reset values of the fields
    localparam logic [2:0] MUX_RST    = 3'h0;
    localparam logic [2:0] GAIN_RST   = 3'h2;
    localparam logic       MODE_RST   = 1'h1;
    localparam logic [2:0] RATE_RST   = 3'h4;
    localparam logic       TEMP_RST   = 1'h0;
    localparam logic       PULLUP_RST = 1'h1;
    localparam logic       MODE_SINGLE = 1'h1;

    // Frame geometry in serial clock edges
    localparam logic [5:0] HALF_BITS  = 6'h10;
    localparam logic [5:0] FRAME_BITS = 6'h20;

    // Serial clock stall timeout
    localparam real REF_CLK_PERIOD_NS   = 10.0;
    localparam real SCLK_TIMEOUT_MS     = 30.8;
    localparam int  SCLK_TIMEOUT_CYCLES = int'(SCLK_TIMEOUT_MS * 1.0e6 / REF_CLK_PERIOD_NS);
    localparam int  TIMEOUT_CNT_W       = 22;

    typedef struct packed {
        logic [2:0] input_pair_sel;
        logic [2:0] gain_range_sel;
        logic       single_shot;
        logic [2:0] sample_rate_sel;
        logic       temp_source_sel;
        logic       pullup_en;
    } setup_type;

    typedef struct packed {
        logic       neg_is_ground;
        logic [1:0] pos_input;
        logic [1:0] neg_input;
    } input_route_type;

    localparam setup_type SETUP_RST = '{MUX_RST, GAIN_RST, MODE_RST, RATE_RST,
                                        TEMP_RST, PULLUP_RST};

    // Read-back image of the stored setup
    function automatic logic [WORD_W-1:0] setup_word(input setup_type s);
        setup_word = {SS_READ, s, WRITE_VALID_CODE, RSVD_READ};
    endfunction : setup_word

    // Full-scale span in millivolts per gain code
    function automatic logic [12:0] full_scale_span(input logic [2:0] g);
        unique case (g)
            3'h0: full_scale_span = 13'h1800;
            3'h1: full_scale_span = 13'h1000;
            3'h2: full_scale_span = 13'h0800;
            3'h3: full_scale_span = 13'h0400;
            3'h4: full_scale_span = 13'h0200;
            default: full_scale_span = 13'h0100;
        endcase
    endfunction : full_scale_span

    // Samples per second per rate code
    function automatic logic [9:0] rate_sps(input logic [2:0] r);
        unique case (r)
            3'h0: rate_sps = 10'h008;
            3'h1: rate_sps = 10'h010;
            3'h2: rate_sps = 10'h020;
            3'h3: rate_sps = 10'h040;
            3'h4: rate_sps = 10'h080;
            3'h5: rate_sps = 10'h0FA;
            3'h6: rate_sps = 10'h1DB;
            default: rate_sps = 10'h35C;
        endcase
    endfunction : rate_sps

    // Input pair per selector code
    function automatic input_route_type input_route(input logic [2:0] m);
        unique case (m)
            3'h0: input_route = '{1'h0, 2'h0, 2'h1};
            3'h1: input_route = '{1'h0, 2'h0, 2'h3};
            3'h2: input_route = '{1'h0, 2'h1, 2'h3};
            3'h3: input_route = '{1'h0, 2'h2, 2'h3};
            default: input_route = '{1'h1, m[1:0], 2'h0};
        endcase
    endfunction : input_route

endpackage : adc_setup_pkg

/* hdl/level_sync.sv */
// Two-flop synchroniser for levels entering the reference clock domain.
// Assumes the inputs are levels or slow toggles, never single-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_type;

    sync_state_type state_reg;
    sync_state_type state_next;

    // First stage feeds only the second
    always_comb
    begin
        state_next.stage1 = async_in;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign sync_out = state_reg.stage2;
endmodule : level_sync
`default_nettype wire

/* hdl/serial_link.sv */
// Serial-clock side of the setup port: shifts bits in and out of a frame.
// Assumes the frame reset is asserted while chip select is high.
`timescale 1ns/10ps
`default_nettype none
module serial_link (
    input  wire logic        sclk,
    input  wire logic        frame_rst_n,
    input  wire logic        reset_n,
    input  wire logic        din,
    input  wire logic [15:0] result_word,
    input  wire logic [15:0] setup_readback,
    output var  logic [15:0] rx_word,
    output var  logic        word_toggle,
    output var  logic        tx_bit,
    output var  logic        started
);
    typedef struct packed {
        logic [5:0]  fall_cnt;
        logic [14:0] rx_shift;
        logic [15:0] readback;
    } rx_state_type;

    typedef struct packed {
        logic [5:0]  rise_cnt;
        logic [15:0] tx_shift;
    } tx_state_type;

    rx_state_type rx_reg;
    rx_state_type rx_next;
    tx_state_type tx_reg;
    tx_state_type tx_next;
    logic [15:0]  word_now;
    logic         half_done;

    assign word_now  = {rx_reg.rx_shift, din};
    assign half_done = (rx_reg.fall_cnt == adc_setup_pkg::HALF_BITS - 6'h1);

    always_comb
    begin
        rx_next = rx_reg;
        if (rx_reg.fall_cnt != adc_setup_pkg::FRAME_BITS)
            rx_next.fall_cnt = rx_reg.fall_cnt + 6'h1;
        rx_next.rx_shift = word_now[14:0];
        if (half_done)
        begin
            if (word_now[adc_setup_pkg::CODE_MSB:adc_setup_pkg::CODE_LSB]
                == adc_setup_pkg::WRITE_VALID_CODE)
                rx_next.readback = {adc_setup_pkg::SS_READ, word_now[14:1],
                                    adc_setup_pkg::RSVD_READ};
            else
                rx_next.readback = setup_readback;
        end
    end

    // frame state cleared while chip select is high
    always_ff @(negedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            rx_reg <= '0;
        else
            rx_reg <= rx_next;
    end

    // Word handoff survives frame resets, so the toggle never fakes an edge
    always_ff @(negedge sclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_word     <= '0;
            word_toggle <= 1'h0;
        end
        else if (frame_rst_n && half_done)
        begin
            rx_word     <= word_now;
            word_toggle <= ~word_toggle;
        end
    end

    // launch on rising edges, MSB first
    always_comb
    begin
        tx_next = tx_reg;
        if (tx_reg.rise_cnt != adc_setup_pkg::FRAME_BITS)
            tx_next.rise_cnt = tx_reg.rise_cnt + 6'h1;
        if (tx_reg.rise_cnt == 6'h0)
            tx_next.tx_shift = result_word;
        else if (tx_reg.rise_cnt == adc_setup_pkg::HALF_BITS)
            tx_next.tx_shift = rx_reg.readback;
        else
            tx_next.tx_shift = {tx_reg.tx_shift[14:0], 1'h0};
    end

    always_ff @(posedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            tx_reg <= '0;
        else
            tx_reg <= tx_next;
    end

    assign tx_bit  = tx_reg.tx_shift[15];
    assign started = (tx_reg.rise_cnt != 6'h0);
endmodule : serial_link
`default_nettype wire

/* testbench/host_spi_model.sv */
// Host-side serial controller model for the converter setup port.
// Assumes mode 1 framing; the testbench calls xfer hierarchically.
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic din,
    input  wire logic dout
);
    localparam int HALF_NS = 6;

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // One framed transfer, MSB first, with an optional pause before a bit
    // launch on rise, sample on fall
    task automatic xfer(input logic [31:0] tx, input int nbits, input int pause_at,
                        input int pause_ns, output logic ready_n, output logic [31:0] rx);
        rx   = '0;
        cs_n = 1'b0;
        #(2*HALF_NS);
        ready_n = dout;
        for (int i = 0; i < nbits; i++)
        begin
            if (i == pause_at)
                #(pause_ns);
            sclk = 1'b1;
            din  = tx[31-i];
            #(HALF_NS);
            sclk = 1'b0;
            rx   = {rx[30:0], dout};
            #(HALF_NS);
        end
        cs_n = 1'b1;
        din  = ~din; // Released line shows no stale level
        #(4*HALF_NS);
    endtask : xfer
endmodule : host_spi_model
`default_nettype wire

/* testbench/adc_config_serial_port_asserts.sv */
// Port-level checker for the converter setup port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module adc_config_serial_port_asserts #(
    parameter int TIMEOUT_CYCLES = 200
) (
    input wire logic                           ref_clk,
    input wire logic                           reset_n,
    input wire logic                           cs_n,
    input wire logic                           conv_busy,
    input wire logic                           dout_oe_n,
    input wire logic                           dout_pullup_on,
    input wire logic                           conv_start,
    input wire adc_setup_pkg::setup_type       setup,
    input wire adc_setup_pkg::input_route_type input_route,
    input wire logic [12:0]                    full_scale_span_mv,
    input wire logic [9:0]                     sample_rate_sps
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [3:0] idle_cnt;

    // Cycles with chip select high; a late update lands within four
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            idle_cnt <= 4'h0;
        else if (!cs_n)
            idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hF)
            idle_cnt <= idle_cnt + 4'h1;
    end

    // Pin driving and pullup
    property p_oe_cs; dout_oe_n == cs_n; endproperty
    a_oe_cs: assert property (p_oe_cs)
        else $error("data pin enable differs from chip select");
    property p_pullup; dout_pullup_on == (cs_n && setup.pullup_en); endproperty
    a_pullup: assert property (p_pullup)
        else $error("pullup state wrong");
    // Decoded spans, rates and routing
    property p_span_hi; setup.gain_range_sel == 3'h0 |-> full_scale_span_mv == 13'h1800;
    endproperty
    a_span_hi: assert property (p_span_hi)
        else $error("widest span wrong");
    property p_span_lo; setup.gain_range_sel[2:1] == 2'h3 |-> full_scale_span_mv == 13'h0100;
    endproperty
    a_span_lo: assert property (p_span_lo)
        else $error("narrowest span wrong");
    property p_rate; setup.sample_rate_sel == 3'h7 |-> sample_rate_sps == 10'h35C; endproperty
    a_rate: assert property (p_rate)
        else $error("top rate wrong");
    property p_route; setup.input_pair_sel[2] |-> input_route ==
        {1'h1, setup.input_pair_sel[1:0], 2'h0}; endproperty
    a_route: assert property (p_route)
        else $error("ground-referenced route wrong");
    // Single-shot start pulse
    property p_start_cause; conv_start |-> $past(setup.single_shot) && !$past(conv_busy);
    endproperty
    a_start_cause: assert property (p_start_cause)
        else $error("start pulse without idle single-shot mode");
    property p_start_pulse; conv_start |=> !conv_start; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse longer than one cycle");
    // No setup change long after a frame
    property p_setup_hold; idle_cnt >= 4'h8 |-> $stable(setup); endproperty
    a_setup_hold: assert property (p_setup_hold)
        else $error("setup changed outside a frame");
endmodule : adc_config_serial_port_asserts

bind adc_config_serial_port adc_config_serial_port_asserts #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) adc_config_serial_port_asserts_inst (.ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n),
    .conv_busy(conv_busy), .dout_oe_n(dout_oe_n), .dout_pullup_on(dout_pullup_on),
    .conv_start(conv_start), .setup(setup), .input_route(input_route),
    .full_scale_span_mv(full_scale_span_mv), .sample_rate_sps(sample_rate_sps));
`default_nettype wire

/* testbench/adc_config_serial_port_tb.sv */
// Self-checking bench for the converter setup port.
// Assumes the host model drives the link; the core side is driven here.
`timescale 1ns/10ps
`default_nettype none
module adc_config_serial_port_tb;
    localparam int TMO = 200; // Short stall limit keeps the run brief
    localparam logic [12:0] SPAN [8] = '{13'h1800, 13'h1000, 13'h0800, 13'h0400,
                                         13'h0200, 13'h0100, 13'h0100, 13'h0100};
    localparam logic [9:0] SPS [8] = '{10'h008, 10'h010, 10'h020, 10'h040,
                                       10'h080, 10'h0FA, 10'h1DB, 10'h35C};
    localparam logic [4:0] ROUTE [8] = '{5'h01, 5'h03, 5'h07, 5'h0B,
                                         5'h10, 5'h14, 5'h18, 5'h1C};
    logic ref_clk, reset_n, sclk, cs_n, din, dout_o, dout_oe_n, dout_pullup_on;
    logic conv_done, conv_busy, conv_start, rdy;
    logic [15:0] conv_data;
    logic [15:0] exp_word;
    logic [15:0] starts = 16'h0000;
    logic [31:0] rx;
    logic [12:0] span;
    logic [9:0] sps;
    adc_setup_pkg::setup_type       setup;
    adc_setup_pkg::input_route_type input_route;
    int fail_count = 0;
    int num_checks = 0;
    wire logic dout_pin;

    // Pin level from driver, pullup or float
    assign dout_pin = !dout_oe_n ? dout_o : (dout_pullup_on ? 1'b1 : 1'bz);

    adc_config_serial_port #(.TIMEOUT_CYCLES(TMO)) adc_config_serial_port_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_o(dout_o), .dout_oe_n(dout_oe_n), .dout_pullup_on(dout_pullup_on),
        .conv_done(conv_done), .conv_data(conv_data), .conv_busy(conv_busy),
        .conv_start(conv_start), .setup(setup), .input_route(input_route),
        .full_scale_span_mv(span), .sample_rate_sps(sps));
    host_spi_model host_spi_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_pin));

    // Reference clock and start-pulse tally
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (conv_start === 1'b1)
            starts <= starts + 16'h0001;

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask : chk_flag

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // Write in a 32-bit frame, then check echo, stored setup and pullup
    task automatic wr_chk(input logic [15:0] w);
        host_spi_model_inst.xfer({w, 16'h0000}, 32, 16, 100, rdy, rx);
        if (w[2:1] == 2'h1)
            exp_word = {1'h0, w[14:1], 1'h1};
        chk_word(rx[15:0], exp_word);
        chk_word({4'h0, setup}, {4'h0, exp_word[14:3]});
        chk_flag(dout_pullup_on, exp_word[3]);
    endtask : wr_chk

    initial
    begin
        #100000;
        fail_count++;
        close_out();
    end

    initial
    begin
        logic [2:0] c;
        reset_n = 1'b0; conv_done = 1'b0; conv_busy = 1'b0; conv_data = 16'h0000;
        exp_word = 16'h058B;
        repeat (6) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        wr_chk(16'h0000);
        wr_chk(16'hFFFF);
        $display("test reset_image done");
        wr_chk(16'h858B);
        chk_word(starts, 16'h0001);
        @(posedge ref_clk); #1 conv_busy = 1'b1;
        wr_chk(16'h858B);
        chk_word(starts, 16'h0001);
        @(posedge ref_clk); #1 conv_busy = 1'b0;
        $display("test single_shot done");
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            wr_chk({1'h0, c, c, 1'h0, c, c[0], c[1], 2'h1, c[2]});
            chk_word({3'h0, span}, {3'h0, SPAN[i]});
            chk_word({6'h00, sps}, {6'h00, SPS[i]});
            chk_word({11'h000, input_route}, {11'h000, ROUTE[i]});
        end
        wr_chk(16'hF0E3);
        chk_word(starts, 16'h0001);
        $display("test decode done");
        for (int k = 0; k < 4; k++)
            if (k != 1)
                wr_chk({13'h0FFF, k[1:0], 1'h0});
        $display("test refused_codes done");
        host_spi_model_inst.xfer({16'h3C53, 16'h0000}, 32, 4, 3000, rdy, rx);
        chk_word({4'h0, setup}, {4'h0, exp_word[14:3]});
        $display("test stall_abort done");
        @(posedge ref_clk); #1 conv_data = 16'hA5C3; conv_done = 1'b1;
        @(posedge ref_clk); #1 conv_done = 1'b0;
        repeat (4) @(posedge ref_clk);
        host_spi_model_inst.xfer(32'h0, 16, 99, 0, rdy, rx);
        chk_flag(rdy, 1'b0);
        chk_word(rx[15:0], 16'hA5C3);
        host_spi_model_inst.xfer(32'h0, 32, 16, 100, rdy, rx);
        chk_flag(rdy, 1'b1);
        chk_word(rx[31:16], 16'hA5C3);
        chk_word(rx[15:0], exp_word);
        $display("test result_frames done");
        close_out();
    end
endmodule : adc_config_serial_port_tb
`default_nettype wire
